/* File: adc_control_sequencer.sv */
// converter control sequencer with apb registers and successive-approximation engine
`timescale 1ns/1ps
`include "adc_control_regs.svh"
module adc_control_sequencer
  import adc_control_pkg::*;
(
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  input  wire logic [3:0]  i_pstrb,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_trigger,
  input  wire logic        i_sleep,
  input  wire logic        i_comparator,
  output logic [3:0]       o_channel,
  output logic [1:0]       o_reference,
  output logic [15:0]      o_analog_mode,
  output logic [9:0]       o_dac_code,
  output logic             o_sample_hold,
  output logic             o_converter_on,
  output logic             o_irq
);
  import adc_control_pkg::*;

  seq_state_t state;
  seq_state_t next_state;
  logic [5:0] ctl0;
  logic [5:0] ctl1;
  logic [3:0] ctl2;
  logic [7:0] result_high;
  logic [7:0] result_low;
  logic       irq_flag;
  logic       irq_enable;
  logic       go;
  logic [5:0] next_ctl0;
  logic [5:0] next_ctl1;
  logic [3:0] next_ctl2;
  logic [7:0] next_result_high;
  logic [7:0] next_result_low;
  logic       next_irq_flag;
  logic       next_irq_enable;
  logic       next_go;
  logic [3:0] bit_idx;
  logic [3:0] next_bit_idx;
  logic [3:0] period;
  logic [3:0] next_period;
  result_t    sar;
  result_t    next_sar;
  logic [2:0] trig_sync;
  logic       trig_level;
  logic       trig_prev;
  logic       cmp_hold;
  logic [2:0] cmp_sync;
  logic       tick;
  logic       use_rc;
  logic       run_clock;
  logic       wr;
  logic       rd;
  logic       sel_ok;
  logic [31:0] next_prdata;

  function automatic logic hit(input logic [11:0] addr, input logic [11:0] ofs);
    hit = (addr == ofs);
  endfunction

  // each step of the code turns one more high input digital, except 0001 which turns two; 1111 is all digital
  function automatic logic [15:0] analog_map(input logic [3:0] cfg);
    logic [15:0] m;
    m = 16'h0000;
    for (int k = 0; k < 16; k++) begin
      m[k] = (cfg == 4'hF) ? 1'b0 : (k < (16 - ((cfg == 4'h0) ? 0 : 32'(cfg) + 1)));
    end
    analog_map = m;
  endfunction

  conv_clock_gen u_clock (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_run      (run_clock),
    .i_select   (ctl2[2:0]),
    .o_tick     (tick),
    .o_use_rc   (use_rc)
  );

  // pin inputs: three flops, change taken when last two agree
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      trig_sync  <= 3'b000;
      trig_level <= 1'b0;
      trig_prev  <= 1'b0;
      cmp_sync   <= 3'b000;
      cmp_hold   <= 1'b0;
    end else begin
      trig_sync  <= {trig_sync[1:0], i_trigger};
      trig_prev  <= trig_level;
      if (trig_sync[2] == trig_sync[1]) begin
        trig_level <= trig_sync[2];
      end
      // four cycles of latency: the two fastest dividers decide on stale answers
      cmp_sync   <= {cmp_sync[1:0], i_comparator};
      if (cmp_sync[2] == cmp_sync[1]) begin
        cmp_hold <= cmp_sync[2];
      end
    end
  end

  assign wr     = i_psel && i_penable && i_pwrite;
  assign rd     = i_psel && !i_pwrite;
  assign sel_ok = hit(i_paddr, `OFS_CONTROL_CHANNEL_GO) || hit(i_paddr, `OFS_REFERENCE_PORT) ||
                  hit(i_paddr, `OFS_CLOCK_FORMAT) || hit(i_paddr, `OFS_RESULT_HIGH) ||
                  hit(i_paddr, `OFS_RESULT_LOW) || hit(i_paddr, `OFS_IRQ_STATUS);
  assign o_pready  = 1'b1;
  assign o_pslverr = i_psel && i_penable && !sel_ok;

  // conversion clock halts in sleep unless the rc source is chosen
  assign run_clock = ctl0[`BIT_MODULE_ENABLE] && !(i_sleep && !use_rc);

  always_comb begin
    next_ctl0        = ctl0;
    next_ctl1        = ctl1;
    next_ctl2        = ctl2;
    next_irq_enable  = irq_enable;
    next_irq_flag    = irq_flag;
    next_result_high = result_high;
    next_result_low  = result_low;
    next_go          = go;
    next_state       = state;
    next_bit_idx     = bit_idx;
    next_period      = period;
    next_sar         = sar;
    if (wr && i_pstrb[0]) begin
      if (hit(i_paddr, `OFS_CONTROL_CHANNEL_GO)) begin
        next_ctl0 = {i_pwdata[5:2], 1'b0, i_pwdata[0]};
        // go may only start from an already-enabled module
        next_go   = i_pwdata[`BIT_GO] && ctl0[`BIT_MODULE_ENABLE] && i_pwdata[0];
      end
      if (hit(i_paddr, `OFS_REFERENCE_PORT)) begin
        next_ctl1 = i_pwdata[5:0];
      end
      if (hit(i_paddr, `OFS_CLOCK_FORMAT)) begin
        next_ctl2 = {i_pwdata[`BIT_RESULT_FORMAT], i_pwdata[2:0]};
      end
      if (hit(i_paddr, `OFS_RESULT_HIGH)) begin
        next_result_high = i_pwdata[7:0];
      end
      if (hit(i_paddr, `OFS_RESULT_LOW)) begin
        next_result_low = i_pwdata[7:0];
      end
      if (hit(i_paddr, `OFS_IRQ_STATUS)) begin
        next_irq_flag   = i_pwdata[`BIT_IRQ_FLAG];
        next_irq_enable = i_pwdata[`BIT_IRQ_ENABLE];
      end
    end
    if (trig_level && !trig_prev && ctl0[`BIT_MODULE_ENABLE]) begin
      next_go = 1'b1;
    end
    case (state)
      ST_IDLE: begin
        if (go && ctl0[`BIT_MODULE_ENABLE]) begin
          next_state   = ST_CONVERT;
          next_period  = 4'h0;
          next_bit_idx = 4'd9;
          next_sar     = 10'h200;
        end
      end
      ST_CONVERT: begin
        if (!go || !ctl0[`BIT_MODULE_ENABLE]) begin
          next_state  = ST_WAIT;
          next_period = 4'h0;
        end else if (tick) begin
          next_period = period + 4'h1;
          // first and last periods frame the ten decisions
          if (period >= 4'h1 && period <= 4'hA) begin
            next_sar[bit_idx] = cmp_hold;
            if (bit_idx != 4'h0) begin
              next_sar[bit_idx - 4'h1] = 1'b1;
              next_bit_idx = bit_idx - 4'h1;
            end
          end
          if (period == 4'(`CONV_PERIODS - 1)) begin
            next_state = ST_FINISH;
          end
        end
      end
      ST_FINISH: begin
        if (ctl2[3]) begin
          next_result_high = {6'h00, sar[9:8]};
          next_result_low  = sar[7:0];
        end else begin
          next_result_high = sar[9:2];
          next_result_low  = {sar[1:0], 6'h00};
        end
        next_go       = 1'b0;
        next_irq_flag = 1'b1;
        next_state    = ST_WAIT;
        next_period   = 4'h0;
      end
      ST_WAIT: begin
        next_go = 1'b0;
        if (!ctl0[`BIT_MODULE_ENABLE]) begin
          next_state = ST_IDLE;
        end else if (tick) begin
          next_period = period + 4'h1;
          if (period == 4'(`WAIT_PERIODS - 1)) begin
            next_state = ST_IDLE;
          end
        end
      end
      default: next_state = ST_IDLE;
    endcase
    // a disabling write wins over a trigger landing in the same cycle
    if (!next_ctl0[`BIT_MODULE_ENABLE]) begin
      next_go = 1'b0;
    end
  end

  always_comb begin
    next_prdata = 32'h0000_0000;
    if (rd) begin
      if (hit(i_paddr, `OFS_CONTROL_CHANNEL_GO)) begin
        next_prdata = {26'h000_0000, ctl0[5:2], go, ctl0[0]};
      end
      if (hit(i_paddr, `OFS_REFERENCE_PORT)) begin
        next_prdata = {26'h000_0000, ctl1};
      end
      if (hit(i_paddr, `OFS_CLOCK_FORMAT)) begin
        next_prdata = {24'h00_0000, ctl2[3], 4'h0, ctl2[2:0]};
      end
      if (hit(i_paddr, `OFS_RESULT_HIGH)) begin
        next_prdata = {24'h00_0000, result_high};
      end
      if (hit(i_paddr, `OFS_RESULT_LOW)) begin
        next_prdata = {24'h00_0000, result_low};
      end
      if (hit(i_paddr, `OFS_IRQ_STATUS)) begin
        next_prdata = {30'h0000_0000, irq_enable, irq_flag};
      end
    end
  end

  // flag is set by completion and otherwise written only by software; the finish cycle wins
  logic set_wins;
  assign set_wins = (state == ST_FINISH);

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      ctl0       <= 6'h00;
      ctl1       <= 6'h00;
      ctl2       <= 4'h0;
      irq_flag   <= 1'b0;
      irq_enable <= 1'b0;
      go         <= 1'b0;
      state      <= ST_IDLE;
      bit_idx    <= 4'h0;
      period     <= 4'h0;
      sar        <= 10'h000;
      o_prdata   <= 32'h0000_0000;
    end else begin
      ctl0       <= next_ctl0;
      ctl1       <= next_ctl1;
      ctl2       <= next_ctl2;
      irq_flag   <= set_wins ? 1'b1 : next_irq_flag;
      irq_enable <= next_irq_enable;
      go         <= next_go;
      state      <= next_state;
      bit_idx    <= next_bit_idx;
      period     <= next_period;
      sar        <= next_sar;
      o_prdata   <= next_prdata;
    end
  end

  // result pair has no reset so its power-up content is unknown
  always_ff @(posedge i_core_clk) begin
    result_high <= next_result_high;
    result_low  <= next_result_low;
  end

  always_comb begin
    o_channel      = ctl0[5:2];
    o_reference    = ctl1[5:4];
    o_analog_mode  = analog_map(ctl1[3:0]);
    o_dac_code     = sar;
    o_sample_hold  = (state != ST_CONVERT);
    o_converter_on = ctl0[`BIT_MODULE_ENABLE];
    o_irq          = irq_flag && irq_enable;
  end

  // cycles spent in the post-conversion wait, frozen while sleep halts the clock
  logic [9:0] wait_cycles;
  logic [9:0] next_wait_cycles;

  always_comb begin
    next_wait_cycles = wait_cycles;
    if (state != ST_WAIT) begin
      next_wait_cycles = 10'h000;
    end else if (run_clock && wait_cycles != 10'h3FF) begin
      next_wait_cycles = wait_cycles + 10'h001;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      wait_cycles <= 10'h000;
    end else begin
      wait_cycles <= next_wait_cycles;
    end
  end

  a_finish_clears: assert property (@(posedge i_core_clk) disable iff (i_rst)
    state == ST_FINISH |=> !go && irq_flag) else $error("completion left go or flag wrong");
  a_disable_stops: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !ctl0[0] |=> !go) else $error("go stayed set while disabled");
  a_abort_wait: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (state == ST_CONVERT && !go && ctl0[0]) |=> state == ST_WAIT) else $error("abort missed");
  a_wait_idle: assert property (@(posedge i_core_clk) disable iff (i_rst)
    wait_cycles <= 10'(3 * `RC_DIV)) else $error("wait never ended");
  a_abort_result: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (state == ST_CONVERT && !go) |=> $stable(result_high) && $stable(result_low))
    else $error("abort changed result");
  a_go_enabled: assert property (@(posedge i_core_clk) disable iff (i_rst)
    $rose(go) |-> ctl0[0]) else $error("go rose while disabled");
  a_right_format: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (state == ST_FINISH && ctl2[3]) |=> result_high[7:2] == 6'h00) else $error("right fmt");
  a_left_format: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (state == ST_FINISH && !ctl2[3]) |=> result_low[5:0] == 6'h00) else $error("left fmt");
  a_ctl_zero: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (rd && (hit(i_paddr, `OFS_CONTROL_CHANNEL_GO) || hit(i_paddr, `OFS_REFERENCE_PORT)))
    |=> o_prdata[31:6] == 26'h000_0000) else $error("unused control bits not zero");
  a_fmt_zero: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (rd && hit(i_paddr, `OFS_CLOCK_FORMAT))
    |=> o_prdata[6:3] == 4'h0 && o_prdata[31:8] == 24'h00_0000)
    else $error("unused format bits not zero");
endmodule

/* File: adc_control_regs.svh */
// register offsets, field positions, reset values and timing counts of the converter sequencer
`ifndef ADC_CONTROL_REGS_SVH
`define ADC_CONTROL_REGS_SVH
`define OFS_CONTROL_CHANNEL_GO 12'h000
`define OFS_REFERENCE_PORT     12'h004
`define OFS_CLOCK_FORMAT       12'h008
`define OFS_RESULT_HIGH        12'h00C
`define OFS_RESULT_LOW         12'h010
`define OFS_IRQ_STATUS         12'h014
`define BIT_MODULE_ENABLE      0
`define BIT_GO                 1
`define BIT_RESULT_FORMAT      7
`define BIT_IRQ_FLAG           0
`define BIT_IRQ_ENABLE         1
`define RST_CONTROL            8'h00
`define RST_RESULT             8'h00
`define CLK_MHZ                125
`define RC_MAX_MHZ             1
`define RC_DIV                 (`CLK_MHZ / `RC_MAX_MHZ)
`define CONV_PERIODS           12
`define WAIT_PERIODS           2
`endif

/* File: adc_control_pkg.sv */
// types shared by the converter sequencer
package adc_control_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CONVERT,
    ST_FINISH,
    ST_WAIT
  } seq_state_t;
  typedef logic [9:0] result_t;
endpackage

/* File: conv_clock_gen.sv */
// conversion clock period tick generator
`timescale 1ns/1ps
`include "adc_control_regs.svh"
module conv_clock_gen (
  input  wire logic       i_core_clk,
  input  wire logic       i_rst,
  input  wire logic       i_run,
  input  wire logic [2:0] i_select,
  output logic            o_tick,
  output logic            o_use_rc
);
  logic [7:0] count;
  logic [7:0] next_count;
  logic [7:0] limit;

  // codes interleave: bit2 doubles the divider, bits1:0 step by four, except 11 which is the rc divider for both bit2 values
  always_comb begin
    o_use_rc = (i_select[1:0] == 2'b11);
    case (i_select)
      3'b000:  limit = 8'h01;
      3'b100:  limit = 8'h03;
      3'b001:  limit = 8'h07;
      3'b101:  limit = 8'h0F;
      3'b010:  limit = 8'h1F;
      3'b110:  limit = 8'h3F;
      default: limit = 8'(`RC_DIV - 1);
    endcase
    if (!i_run) begin
      next_count = 8'h00;
    end else if (count >= limit) begin
      next_count = 8'h00;
    end else begin
      next_count = count + 8'h01;
    end
    o_tick = i_run && (count >= limit);
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      count <= 8'h00;
    end else begin
      count <= next_count;
    end
  end

  a_tick_rate: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_run && i_select == 3'b000 && o_tick) ##1 (i_run && i_select == 3'b000)
    |-> !o_tick ##1 (!(i_run && i_select == 3'b000) || o_tick))
    else $error("divide-by-two tick spacing wrong");
endmodule

/* File: analog_front_model.sv */
// behavioural sample-and-hold and comparator facing the sequencer
`timescale 1ns/1ps
module analog_front_model (
  input  wire logic       i_core_clk,
  input  wire logic       i_sample_hold,
  input  wire logic [9:0] i_level,
  input  wire logic [9:0] i_dac_code,
  output logic            o_comparator
);
  logic [9:0] held;
  logic       junk;
  initial junk = 1'b0;
  // held value freezes once the hold phase starts
  always @(posedge i_core_clk) begin
    junk <= ~junk;
    if (i_sample_hold) begin
      held <= i_level;
    end
  end
  // answer is meaningless while tracking, so it toggles rather than looking valid
  assign o_comparator = i_sample_hold ? junk : (held >= i_dac_code);
endmodule

/* File: adc_control_sequencer_tb.sv */
// self-checking bench for the converter control sequencer
`timescale 1ns/1ps
module adc_control_sequencer_tb;
  logic        clk, rst, psel, penable, pwrite, trig, sleep, cmp, sh, pready, pslverr;
  logic        conv_on, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  ch;
  logic [1:0]  refs;
  logic [15:0] amode, rnd;
  logic [9:0]  dac, level;
  logic [7:0]  exp_hi, exp_lo;
  int          error_cnt, check_count, cyc;

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;

  adc_control_sequencer u_adc_control_sequencer (.i_core_clk(clk), .i_rst(rst),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .i_pstrb(4'hF), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_trigger(trig), .i_sleep(sleep), .i_comparator(cmp),
    .o_channel(ch), .o_reference(refs), .o_analog_mode(amode), .o_dac_code(dac),
    .o_sample_hold(sh), .o_converter_on(conv_on), .o_irq(irq));
  analog_front_model u_analog_front_model (.i_core_clk(clk), .i_sample_hold(sh),
    .i_level(level), .i_dac_code(dac), .o_comparator(cmp));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic int div(input logic [2:0] cs);
    case (cs)
      3'b000: return 2;
      3'b100: return 4;
      3'b001: return 8;
      3'b101: return 16;
      3'b010: return 32;
      3'b110: return 64;
      default: return 125;
    endcase
  endfunction
  function automatic logic [15:0] mode_exp(input logic [3:0] k);
    if (k == 4'h0) return 16'hFFFF;
    if (k == 4'hF) return 16'h0000;
    return 16'hFFFF >> (k + 4'h1);
  endfunction
  function automatic logic [15:0] pack(input logic [9:0] v, input logic fmt);
    return fmt ? {6'h00, v} : {v, 6'h00};
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t ns: seen %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic hang();
    error_cnt++;
    $display("[ERR] %0t ns: wait ran out", $time);
    give_verdict();
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // values read here are those this rising edge samples
    for (n = 0; pready !== 1'b1; n++) begin
      if (n > 50) hang();
      @(posedge clk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, {24'h00_0000, d}, q, e);
  endtask
  task automatic rd(input logic [11:0] a, output logic [15:0] q);
    logic [31:0] w;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, w, e);
    q = w[15:0];
  endtask
  task automatic wait_go(output int d);
    logic [15:0] q;
    int          t0;
    int          n;
    t0 = cyc;
    rd(12'h000, q);
    for (n = 0; q[1] === 1'b1; n++) begin
      if (n > 800) hang();
      rd(12'h000, q);
    end
    d = cyc - t0;
  endtask
  // go writes during the post-conversion wait are dropped
  task automatic settle();
    repeat (2 * div(3'b011) + 8) @(posedge clk);
  endtask
  task automatic results(input logic fmt);
    logic [15:0] q;
    {exp_hi, exp_lo} = pack(level, fmt);
    rd(12'h00C, q);
    check(q, {8'h00, exp_hi});
    rd(12'h010, q);
    check(q, {8'h00, exp_lo});
  endtask
  task automatic convert(input logic [3:0] c, input logic [2:0] cs, input logic fmt);
    logic [15:0] q;
    int          d;
    settle();
    rnd = lfsr(rnd);
    level <= rnd[9:0];
    wr(12'h008, {fmt, 4'h0, cs});
    wr(12'h000, {2'b00, c, 2'b01});
    wr(12'h000, {2'b00, c, 2'b11});
    check(16'(ch), 16'(c));
    wait_go(d);
    check(16'(d >= 11 * div(cs) && d <= 13 * div(cs) + 24), 16'h0001);
    results(fmt);
    rd(12'h014, q);
    check(16'(q[0]), 16'h0001);
  endtask

  initial begin
    logic [15:0] q;
    logic [31:0] q32;
    logic        e;
    int          k;
    int          d;
    logic [2:0]  codes [5];
    codes = '{3'b101, 3'b010, 3'b110, 3'b011, 3'b111};
    {rst, psel, penable, pwrite, trig, sleep} = 6'b100000;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    level = 10'h000;
    rnd = 16'h3704;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (k = 0; k < 4; k++) begin
      rd(12'(k == 3 ? 20 : k * 4), q);
      check(q, 16'h0000);
    end
    check(16'(conv_on), 16'h0000);
    apb(1'b0, 12'h01C, 32'h0000_0000, q32, e);
    check({15'h0000, e}, 16'h0001);
    check(q32[15:0], 16'h0000);
    $display("test reset and map done");
    for (k = 0; k < 16; k++) begin
      rnd = lfsr(rnd);
      wr(12'h004, {rnd[7:4], 4'(k)});
      rd(12'h004, q);
      check(q, {10'h000, rnd[5:4], 4'(k)});
      check(amode, mode_exp(4'(k)));
      check(16'(refs), 16'(rnd[5:4]));
      wr(12'h008, rnd[15:8]);
      rd(12'h008, q);
      check(q, {8'h00, rnd[15:8] & 8'h87});
      wr(12'h000, {rnd[7:6], 4'(k), 2'b01});
      rd(12'h000, q);
      check(q, {10'h000, 4'(k), 2'b01});
      check(16'(ch), 16'(k));
      check(16'(conv_on), 16'h0001);
    end
    wr(12'h008, 8'h00);
    repeat (8) @(posedge clk);
    wr(12'h000, 8'h00);
    @(negedge clk);
    check(16'(conv_on), 16'h0000);
    wr(12'h000, 8'h03);
    rd(12'h000, q);
    check(16'(q[1]), 16'h0000);
    $display("test registers done");
    wr(12'h014, 8'h02);
    for (k = 0; k < 5; k++) begin
      rnd = lfsr(rnd);
      convert(rnd[3:0], codes[k], k[0]);
      check(16'(irq), 16'h0001);
      wr(12'h014, 8'h02);
      @(negedge clk);
      check(16'(irq), 16'h0000);
    end
    wr(12'h014, 8'h00);
    convert(4'h5, 3'b010, 1'b1);
    check(16'(irq), 16'h0000);
    wr(12'h014, 8'h00);
    $display("test conversions done");
    settle();
    sleep <= 1'b1;
    convert(4'h2, 3'b011, 1'b0);
    settle();
    wr(12'h008, 8'h02);
    wr(12'h000, 8'h01);
    wr(12'h000, 8'h03);
    repeat (1000) @(posedge clk);
    rd(12'h000, q);
    check(16'(q[1]), 16'h0001);
    sleep <= 1'b0;
    wait_go(d);
    results(1'b0);
    settle();
    $display("test sleep done");
    wr(12'h014, 8'h00);
    wr(12'h008, 8'h03);
    level <= ~level;
    wr(12'h000, 8'h03);
    repeat (300) @(posedge clk);
    wr(12'h000, 8'h01);
    rd(12'h00C, q);
    check(q, {8'h00, exp_hi});
    rd(12'h010, q);
    check(q, {8'h00, exp_lo});
    rd(12'h014, q);
    check(16'(q[0]), 16'h0000);
    repeat (2 * 125 + 24) @(posedge clk);
    check(16'(sh), 16'h0001);
    wr(12'h000, 8'h03);
    rd(12'h000, q);
    check(16'(q[1]), 16'h0001);
    $display("test abort done");
    wr(12'h000, 8'h00);
    trig <= 1'b1;
    repeat (8) @(posedge clk);
    trig <= 1'b0;
    repeat (8) @(posedge clk);
    rd(12'h000, q);
    check(16'(q[1]), 16'h0000);
    wr(12'h000, 8'h01);
    trig <= 1'b1;
    repeat (8) @(posedge clk);
    trig <= 1'b0;
    rd(12'h000, q);
    check(16'(q[1]), 16'h0001);
    wait_go(d);
    results(1'b0);
    $display("test trigger done");
    settle();
    wr(12'h000, 8'h03);
    repeat (100) @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(12'h000, q);
    check(q, 16'h0000);
    rd(12'h008, q);
    check(q, 16'h0000);
    check(16'(conv_on), 16'h0000);
    rd(12'h00C, q);
    check(q, {8'h00, exp_hi});
    $display("test reset in flight done");
    give_verdict();
  end

  // run-length guard
  initial begin
    repeat (100000) @(posedge clk);
    hang();
  end
endmodule
